// *** inc/pdps_pkg.sv ***
// Constants and types for the post divider phase shift register block
`default_nettype none
package pdps_pkg;
	localparam int          NUM_DIV      = 5;
	localparam int          COARSE_W     = 13;
	localparam int          FINE_W       = 3;
	localparam int          DEG_W        = 9;
	localparam int          FINE_LSB     = 13;
	localparam int          OSC_DIS_BIT  = 0;
	localparam int          REV_TOP_W    = 2;
	// Byte address of the high byte of each divider register
	localparam logic [7:0]  DIV_BASE [NUM_DIV] = '{
		8'hC1, 8'hC7, 8'hC9, 8'hCB, 8'hCD
	};
	localparam logic [7:0]  OSC_SEL_ADDR = 8'hC3;
	localparam logic [7:0]  REV_ADDR     = 8'hC6;
	localparam logic [15:0] DIV_RESET    = 16'h0000;
	localparam logic [7:0]  OSC_RESET    = 8'h00;
	localparam logic [7:0]  RDATA_NONE   = 8'h00;
	localparam logic [2:0]  IDX_NONE     = 3'h7;

	typedef struct packed {
		logic signed [COARSE_W-1:0] period_offset;
		logic [FINE_W-1:0]          fine_offset;
		logic signed [DEG_W-1:0]    fine_deg;
		logic                       advance;
		logic                       delay;
	} pdps_div_cfg_s;
endpackage : pdps_pkg
`default_nettype wire

// *** rtl/pdps_top.sv ***
// Phase shift configuration registers for five synthesizer post dividers
//
// Function
// R1 - Coarse shift is bits 12:0, two's complement synthesizer periods.
// R2 - Zero coarse: no shift; negative delays, positive advances a period.
// R3 - Coarse and fine settings of one divider apply together, per divider.
// R4 - Three-bit fine shift sits in bits 15:13, steps of 45 degrees.
// R5 - Fine codes decode 0,-45,-90,-135,180,135,90,45 degrees in order.
// R6 - Oscillator select bit 0 low enables driver, high disables it.
// R7 - Software sets select high for external oscillator, low for crystal.
// R8 - Readable revision byte combines with bits 6:5 of register zero.
// R9 - Sixteen-bit registers span two bytes, high byte at lower address.
`default_nettype none
module pdps_top
	import pdps_pkg::*;
#(
	// Arbitrary neutral revision value
	parameter logic [7:0] REVISION_BYTE = 8'h5A
) (
	input  wire logic                 CLOCK,
	input  wire logic                 SRST,
	input  wire logic [7:0]           REG_ADDR,
	input  wire logic                 REG_WR,
	input  wire logic [7:0]           REG_WDATA,
	input  wire logic                 REG_RD,
	input  wire logic [REV_TOP_W-1:0] REV_TOP_BITS,
	output var  logic [7:0]           REG_RDATA,
	output var  logic                 REG_RVALID,
	output var  pdps_div_cfg_s        DIV_CFG [NUM_DIV],
	output var  logic [NUM_DIV-1:0]   CFG_UPDATE,
	output var  logic                 OSC_DRIVER_EN,
	output var  logic [9:0]           FULL_REVISION
);

	logic [15:0]          div_reg        [NUM_DIV];
	logic [15:0]          next_div_reg   [NUM_DIV];
	logic [7:0]           stage          [NUM_DIV];
	logic [7:0]           next_stage     [NUM_DIV];
	pdps_div_cfg_s        next_cfg       [NUM_DIV];
	logic [NUM_DIV-1:0]   next_update;
	logic                 osc_driver_disable;
	logic                 next_osc_driver_disable;
	logic [7:0]           rev_byte;
	logic [7:0]           next_rev_byte;
	logic [7:0]           next_rdata;
	logic                 next_rvalid;
	logic                 next_osc_en;
	logic [9:0]           next_full_rev;
	logic [3:0]           wr_dec;
	logic [3:0]           rd_dec;

	// Address to {low byte, divider index}; index 7 when unmapped
	function automatic logic [3:0] decode_div(input logic [7:0] a);
		logic [3:0] r;
		r = {1'b0, IDX_NONE};
		for (int i = 0; i < NUM_DIV; i++) begin
			if (a == DIV_BASE[i])
				r = {1'b0, 3'(i)};
			else if (a == DIV_BASE[i] + 8'h01)
				r = {1'b1, 3'(i)};
		end
		return r;
	endfunction : decode_div

	// R5 fine code decode
	function automatic logic signed [DEG_W-1:0] fine_to_deg(
		input logic [FINE_W-1:0] c
	);
		logic signed [DEG_W-1:0] d;
		d = 9'sd0;
		unique case (c)
			3'h0: d = 9'sd0;
			3'h1: d = -9'sd45;
			3'h2: d = -9'sd90;
			3'h3: d = -9'sd135;
			3'h4: d = 9'sd180;
			3'h5: d = 9'sd135;
			3'h6: d = 9'sd90;
			3'h7: d = 9'sd45;
		endcase
		return d;
	endfunction : fine_to_deg

	assign wr_dec = decode_div(REG_ADDR);
	assign rd_dec = decode_div(REG_ADDR);

	always_comb begin
		next_update = '0;
		for (int i = 0; i < NUM_DIV; i++) begin
			next_div_reg[i] = div_reg[i];
			next_stage[i]   = stage[i];
		end
		next_osc_driver_disable = osc_driver_disable;
		next_rev_byte           = rev_byte;
		if (REG_WR) begin
			if (wr_dec[2:0] != IDX_NONE) begin
				// R9 high byte staged, low byte commits
				if (!wr_dec[3]) begin
					next_stage[wr_dec[2:0]] = REG_WDATA;
				end else begin
					// R3 both fields commit at once
					next_div_reg[wr_dec[2:0]] = {stage[wr_dec[2:0]], REG_WDATA};
					next_update[wr_dec[2:0]]  = 1'b1;
				end
			end else if (REG_ADDR == OSC_SEL_ADDR) begin
				next_osc_driver_disable = REG_WDATA[OSC_DIS_BIT];
			end else if (REG_ADDR == REV_ADDR) begin
				next_rev_byte = REG_WDATA;
			end
		end
		for (int i = 0; i < NUM_DIV; i++) begin
			// R1 coarse field, R4 fine field
			next_cfg[i].period_offset = next_div_reg[i][COARSE_W-1:0];
			next_cfg[i].fine_offset   = next_div_reg[i][15:FINE_LSB];
			next_cfg[i].fine_deg      =
				fine_to_deg(next_div_reg[i][15:FINE_LSB]);
			// R2 direction from sign
			next_cfg[i].advance = !next_div_reg[i][COARSE_W-1]
				&& (next_div_reg[i][COARSE_W-1:0] != '0);
			next_cfg[i].delay   = next_div_reg[i][COARSE_W-1];
		end
		// R6 active high disable bit
		next_osc_en   = !next_osc_driver_disable;
		// R8 full revision
		next_full_rev = {REV_TOP_BITS, next_rev_byte};
		next_rvalid   = REG_RD;
		next_rdata    = RDATA_NONE;
		if (REG_RD) begin
			if (rd_dec[2:0] != IDX_NONE)
				next_rdata = rd_dec[3] ? div_reg[rd_dec[2:0]][7:0]
					: div_reg[rd_dec[2:0]][15:8];
			else if (REG_ADDR == OSC_SEL_ADDR)
				next_rdata = {7'h00, osc_driver_disable};
			else if (REG_ADDR == REV_ADDR)
				next_rdata = rev_byte;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			for (int i = 0; i < NUM_DIV; i++) begin
				div_reg[i] <= DIV_RESET;
				stage[i]   <= 8'h00;
				DIV_CFG[i] <= '0;
			end
			CFG_UPDATE         <= '0;
			osc_driver_disable <= OSC_RESET[OSC_DIS_BIT];
			rev_byte           <= REVISION_BYTE;
			OSC_DRIVER_EN      <= 1'b1;
			FULL_REVISION      <= {2'h0, REVISION_BYTE};
			REG_RDATA          <= RDATA_NONE;
			REG_RVALID         <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_DIV; i++) begin
				div_reg[i] <= next_div_reg[i];
				stage[i]   <= next_stage[i];
				DIV_CFG[i] <= next_cfg[i];
			end
			CFG_UPDATE         <= next_update;
			osc_driver_disable <= next_osc_driver_disable;
			rev_byte           <= next_rev_byte;
			OSC_DRIVER_EN      <= next_osc_en;
			FULL_REVISION      <= next_full_rev;
			REG_RDATA          <= next_rdata;
			REG_RVALID         <= next_rvalid;
		end
	end

	generate
		for (genvar g = 0; g < NUM_DIV; g++) begin : g_chk
			AST_COARSE_FIELD: assert property ( // R1
				@(posedge CLOCK) disable iff (SRST)
				REG_WR && REG_ADDR == DIV_BASE[g] + 8'h01
				|=> DIV_CFG[g].period_offset
					== {stage[g][4:0], $past(REG_WDATA)})
				else $error("Coarse offset not taken from low bits");
			AST_DIRECTION: assert property ( // R2
				@(posedge CLOCK) disable iff (SRST)
				(DIV_CFG[g].period_offset == '0 |-> !DIV_CFG[g].advance
					&& !DIV_CFG[g].delay)
				and (DIV_CFG[g].period_offset < 0 |-> DIV_CFG[g].delay)
				and (DIV_CFG[g].period_offset > 0 |-> DIV_CFG[g].advance))
				else $error("Shift direction wrong for coarse value");
			AST_TOGETHER: assert property ( // R3
				@(posedge CLOCK) disable iff (SRST)
				!CFG_UPDATE[g] && !$past(SRST) |-> $stable(DIV_CFG[g]))
				else $error("Divider setting changed without commit");
			AST_FINE_FIELD: assert property ( // R4
				@(posedge CLOCK) disable iff (SRST)
				CFG_UPDATE[g] |-> DIV_CFG[g].fine_offset == div_reg[g][15:13])
				else $error("Fine offset not from top bits");
			AST_FINE_DEG: assert property ( // R5
				@(posedge CLOCK) disable iff (SRST)
				(DIV_CFG[g].fine_offset == 3'h3 |-> DIV_CFG[g].fine_deg == -135)
				and (DIV_CFG[g].fine_offset == 3'h4
					|-> DIV_CFG[g].fine_deg == 180)
				and (DIV_CFG[g].fine_offset == 3'h7
					|-> DIV_CFG[g].fine_deg == 45))
				else $error("Fine phase decode wrong");
			AST_HIGH_BYTE_HOLD: assert property ( // R9
				@(posedge CLOCK) disable iff (SRST)
				REG_WR && REG_ADDR == DIV_BASE[g] ##1 !CFG_UPDATE[g]
				|-> stage[g] == $past(REG_WDATA) && $stable(div_reg[g]))
				else $error("High byte write altered live setting");
		end
	endgenerate

	AST_OSC_DRIVER: assert property ( // R6
		@(posedge CLOCK) disable iff (SRST)
		REG_WR && REG_ADDR == OSC_SEL_ADDR
		|=> OSC_DRIVER_EN == !$past(REG_WDATA[0]))
		else $error("Oscillator driver enable wrong");
	AST_REVISION: assert property ( // R8
		@(posedge CLOCK) disable iff (SRST)
		!$past(SRST) |-> FULL_REVISION
			== {$past(REV_TOP_BITS), $past(next_rev_byte)})
		else $error("Full revision not combined");
	AST_READ_REV: assert property ( // R8
		@(posedge CLOCK) disable iff (SRST)
		REG_RD && REG_ADDR == REV_ADDR && !REG_WR
		|=> REG_RVALID ##0 REG_RDATA == rev_byte)
		else $error("Revision byte read back wrong");

endmodule : pdps_top
`default_nettype wire

// *** testbench/pdps_top_test.sv ***
// Self-checking bench for the post divider phase shift registers
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module pdps_top_test
	import pdps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Arbitrary neutral revision value
	localparam logic [7:0] REV = 8'h3C;
	logic               clock = 1'b0;
	logic               srst = 1'b1;
	logic [7:0]         reg_addr = 8'h00;
	logic               reg_wr = 1'b0;
	logic [7:0]         reg_wdata = 8'h00;
	logic               reg_rd = 1'b0;
	logic [1:0]         rev_top = 2'b10;
	logic [7:0]         reg_rdata;
	logic               reg_rvalid;
	pdps_div_cfg_s      div_cfg [NUM_DIV];
	logic [NUM_DIV-1:0] cfg_update;
	logic               osc_en;
	logic [9:0]         full_rev;
	int                 n_fail = 0;
	int                 comparisons = 0;
	logic signed [8:0]  deg [8] = '{0, -45, -90, -135, 180, 135, 90, 45};
	logic [15:0]        vals [NUM_DIV] = '{16'h1000, 16'h0FFF, 16'hFFFF,
		16'h6001, 16'h3456};

	pdps_top #(.REVISION_BYTE(REV)) dut (.CLOCK(clock), .SRST(srst),
		.REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
		.REG_RD(reg_rd), .REV_TOP_BITS(rev_top), .REG_RDATA(reg_rdata),
		.REG_RVALID(reg_rvalid), .DIV_CFG(div_cfg), .CFG_UPDATE(cfg_update),
		.OSC_DRIVER_EN(osc_en), .FULL_REVISION(full_rev));

	always #20 clock = ~clock;

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clock);
		#1;
		reg_rd = 1'b0;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_rdata, e)
	endtask : rd

	task automatic wr16(input int i, input logic [15:0] v);
		wr(DIV_BASE[i], v[15:8]);
		wr(DIV_BASE[i] + 8'h01, v[7:0]);
		`CHK(cfg_update, NUM_DIV'(1 << i))
		@(posedge clock);
		#1;
		`CHK(cfg_update, '0)
	endtask : wr16

	task automatic t_reset();
		`CHK(osc_en, 1'b1)
		`CHK(full_rev, {2'b00, REV})
		for (int i = 0; i < NUM_DIV; i++) begin
			rd(DIV_BASE[i], 8'h00);
			rd(DIV_BASE[i] + 8'h01, 8'h00);
		end
		rd(REV_ADDR, REV);
		rd(OSC_SEL_ADDR, 8'h00);
		`CHK(full_rev, {2'b10, REV})
	endtask : t_reset

	task automatic t_fine();
		int co;
		for (int c = 0; c < 8; c++) begin
			co = c * 3 - 9;
			wr16(0, {c[2:0], 13'(co)});
			`CHK(div_cfg[0].fine_offset, c[2:0])
			`CHK(div_cfg[0].fine_deg, deg[c])
			`CHK(div_cfg[0].period_offset, 13'(co))
			`CHK(div_cfg[0].advance, co > 0)
			`CHK(div_cfg[0].delay, co < 0)
			`CHK(div_cfg[1], '0)
		end
	endtask : t_fine

	task automatic t_each();
		for (int i = 0; i < NUM_DIV; i++)
			wr16(i, vals[i]);
		for (int i = 0; i < NUM_DIV; i++) begin
			rd(DIV_BASE[i], vals[i][15:8]);
			rd(DIV_BASE[i] + 8'h01, vals[i][7:0]);
			`CHK(div_cfg[i].period_offset, vals[i][12:0])
			`CHK(div_cfg[i].fine_offset, vals[i][15:13])
			`CHK(div_cfg[i].delay, vals[i][12])
			`CHK(div_cfg[i].advance, !vals[i][12])
		end
	endtask : t_each

	task automatic t_osc_misc();
		wr(OSC_SEL_ADDR, 8'hFF);
		`CHK(osc_en, 1'b0)
		rd(OSC_SEL_ADDR, 8'h01);
		wr(OSC_SEL_ADDR, 8'hFE);
		`CHK(osc_en, 1'b1)
		wr(8'hC5, 8'h77);
		rd(8'hC5, 8'h00);
		rev_top = 2'b01;
		@(posedge clock);
		#1;
		`CHK(full_rev, {2'b01, REV})
	endtask : t_osc_misc

	initial begin
		repeat (5) @(posedge clock);
		#1;
		srst = 1'b0;
		t_reset();
		t_fine();
		t_each();
		t_osc_misc();
		end_sim();
	end

	initial begin
		#50us;
		n_fail++;
		end_sim();
	end
endmodule : pdps_top_test
`default_nettype wire
